// file: common/acc_pkg.sv
// Package: register map, field positions and timing constants of the converter
package acc_pkg;
	// Register word addresses (one register per bus address)
	localparam logic [3:0] OFF_CFG   = 4'h0;
	localparam logic [3:0] OFF_SC2   = 4'h1;
	localparam logic [3:0] OFF_SC1   = 4'h2;
	localparam logic [3:0] OFF_RESH  = 4'h3;
	localparam logic [3:0] OFF_RESL  = 4'h4;
	localparam logic [3:0] OFF_CMPH  = 4'h5;
	localparam logic [3:0] OFF_CMPL  = 4'h6;
	localparam logic [3:0] OFF_PIN1  = 4'h7;
	localparam logic [3:0] OFF_PIN2  = 4'h8;
	localparam logic [3:0] OFF_PWR   = 4'h9;
	localparam int         ADDR_LSB  = 2;
	// Configuration fields
	localparam int         CFG_LP    = 7;
	localparam int         CFG_DIV   = 5;
	localparam int         CFG_LSMP  = 4;
	localparam int         CFG_RES   = 2;
	localparam int         CFG_ICLK  = 0;
	// Status/control two fields
	localparam int         SC2_ACT   = 7;
	localparam int         SC2_TRG   = 6;
	localparam int         SC2_CFE   = 5;
	localparam int         SC2_CGT   = 4;
	localparam logic [7:0] SC2_WMASK = 8'h70;
	// Status/control one fields
	localparam int         SC1_COMPLETION_FLAG  = 7;
	localparam int         SC1_IEN   = 6;
	localparam int         SC1_CONT  = 5;
	localparam logic [4:0] CH_OFF    = 5'h1F;
	// Reset values
	localparam logic [7:0] CFG_RST   = 8'h00;
	localparam logic [7:0] SC2_RST   = 8'h00;
	localparam logic [7:0] SC1_RST   = 8'h1F;
	localparam logic [7:0] PIN_RST   = 8'h00;
	// Encodings
	localparam logic [1:0] RES_10BIT = 2'b10;
	localparam logic [1:0] ICLK_BUS  = 2'b00;
	localparam logic [1:0] ICLK_ASYN = 2'b11;
	// Power mode codes in the power register
	localparam logic [1:0] PWR_RUN   = 2'b00;
	localparam logic [1:0] PWR_STOP3 = 2'b01;
	localparam logic [1:0] PWR_DEEP  = 2'b10;
	// Sample lengths in conversion clock cycles
	localparam int         SMP_SHORT = 4;
	localparam int         SMP_LONG  = 24;
	localparam int         CNT_W     = 6;
endpackage

// file: verilog/acc_core.sv
// Converter control logic: registers, sequencing, compare and low-power
`timescale 1ns/1ns
// What this block does
// - Stop3 without async clock aborts conversion and returns to idle.
// - Stop3 entry or exit leaves result registers unchanged.
// - After aborted stop3, stay idle until new trigger.
// - With async clock, conversion continues through stop3 to completion.
// - In stop3 with async clock, hardware trigger or continuous starts.
// - Completion in stop3 sets flag, raises wake interrupt if enabled.
// - Stop1/stop2 disable converter and reset all registers except the power mode.
// - Configuration: low power 7, divider 6:5, long 4, res 3:2, clk 1:0.
// - Divider 00 makes conversion clock equal to input clock.
// - Resolution 10 selects 10-bit conversions.
// - Input clock select 00 picks bus clock.
// - Control two: active 7, trigger 6, compare enable 5, direction 4.
// - Control two bits 3:2 read zero; software writes zero to 1:0.
// - Control one: completion 7 read-only, irq 6, continuous 5, channel 4:0.
// - Continuous select 0 gives one conversion per trigger.
// - Channel value 00001 routes input channel 1.
// - Compare value pair holds the limit for automatic compare.
// - Pin control bit set disables digital control of that pin.
// - In 10-bit mode, high read, low unread: block transfer, flag clear, discard result.
// - Control one write aborts and restarts unless channel all ones.
// - Direction 1 flags at or above compare; 0 flags below.
module acc_core
	import acc_pkg::*;
#(
	parameter int RES_BITS = 10,
	parameter int N_CH     = 16
)(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        async_clk_tick,
	input  wire logic        hw_trigger,
	output logic      [4:0]  analog_channel,
	output logic             sample_request,
	input  wire logic        compare_step,
	input  wire logic [9:0]  analog_sample,
	output logic      [15:0] pin_digital_disable,
	output logic             wake_irq
);
	initial begin
		if (RES_BITS != 10 || N_CH > 16 || N_CH < 1)
			$error("acc_core: unsupported parameters");
	end

	typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT} acc_state_t;

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for pin-level inputs
	logic [2:0] trg_s_q;
	logic [1:0] tick_s_q;
	always_ff @(posedge clk) begin
		trg_s_q  <= {trg_s_q[1:0], hw_trigger};
		tick_s_q <= {tick_s_q[0], async_clk_tick};
	end
	wire trg_rise = trg_s_q[1] & ~trg_s_q[2];

	////////////////////////////////////////////////////////////////////////
	// Bus decode: waitrequest high one cycle, answer on the second
	logic        ack_q;
	logic [7:0]  cfg_q, sc2_q, sc1_q, cmph_q, cmpl_q, pin1_q, pin2_q;
	logic [1:0]  pwr_q;
	logic [9:0]  res_q;
	logic        completion_flag_q, act_q, hi_read_q;
	acc_state_t  st_q;
	logic [CNT_W-1:0] cnt_q;
	logic [3:0]  div_q;
	logic [3:0]  bit_q;
	logic [9:0]  sar_q;
	logic        half_q;

	wire wr      = avs_write & ack_q;
	wire rd      = avs_read & ack_q;
	wire wr_cfg  = wr && avs_address == OFF_CFG;
	wire wr_sc2  = wr && avs_address == OFF_SC2;
	wire wr_sc1  = wr && avs_address == OFF_SC1;
	wire wr_cmph = wr && avs_address == OFF_CMPH;
	wire wr_cmpl = wr && avs_address == OFF_CMPL;
	wire wr_pin1 = wr && avs_address == OFF_PIN1;
	wire wr_pin2 = wr && avs_address == OFF_PIN2;
	wire wr_pwr  = wr && avs_address == OFF_PWR;
	wire rd_resh = rd && avs_address == OFF_RESH;
	wire rd_resl = rd && avs_address == OFF_RESL;
	wire [7:0] wd = avs_writedata[7:0];

	wire stop3    = pwr_q == PWR_STOP3;
	wire deep     = pwr_q == PWR_DEEP;
	wire asyn_sel = cfg_q[CFG_ICLK +: 2] == ICLK_ASYN;
	wire stop3_kill = wr_pwr && wd[1:0] == PWR_STOP3 && !asyn_sel;

	////////////////////////////////////////////////////////////////////////
	// Conversion clock: source select then divide by 1,2,4,8
	wire src_tick = asyn_sel ? tick_s_q[1]
		: (cfg_q[CFG_ICLK +: 2] == ICLK_BUS ? 1'b1 : half_q);
	wire [3:0] div_lim = 4'(({3'b000, 1'b1} << cfg_q[CFG_DIV +: 2]) - 1);
	wire conversion_clock = src_tick && div_q == div_lim;
	wire stopped_clk = stop3 && !asyn_sel;

	wire [9:0] cmp_val = {cmph_q[1:0], cmpl_q};
	wire ten_bit  = cfg_q[CFG_RES +: 2] == RES_10BIT;
	wire [3:0] nbits  = ten_bit ? 4'd10 : 4'd8;
	wire [9:0] conv_res = ten_bit ? sar_q : {2'b00, sar_q[9:2]};
	wire [9:0] cmp_diff = conv_res - cmp_val;
	wire cmp_ok = !sc2_q[SC2_CFE] ||
		(sc2_q[SC2_CGT] ? conv_res >= cmp_val : conv_res < cmp_val);
	wire sc2_abort = wr_cfg | wr_sc2 | wr_cmph | wr_cmpl;
	wire sw_start  = wr_sc1 && wd[4:0] != CH_OFF;
	wire hw_start  = sc2_q[SC2_TRG] && trg_rise &&
		sc1_q[4:0] != CH_OFF;
	wire conv_done = st_q == ACC_CONVERT && conversion_clock && bit_q == 4'd1;
	wire blocked   = hi_read_q && ten_bit;
	wire transfer  = conv_done && cmp_ok && !blocked;
	// Restart: continuous, or blocked result unless single failed compare
	wire restart   = conv_done && (sc1_q[SC1_CONT] ||
		(blocked && cmp_ok));
	wire abort     = sc2_abort | stop3_kill | wr_sc1;
	wire start     = sw_start | (hw_start && st_q == ACC_IDLE) | restart;

	////////////////////////////////////////////////////////////////////////
	// Registers; deep stop forces every register except the power mode back to reset
	wire sreset = !resetn || deep;
	always_ff @(posedge clk) begin
		if (sreset) begin
			cfg_q  <= CFG_RST;
			sc2_q  <= SC2_RST;
			sc1_q  <= SC1_RST;
			cmph_q <= 8'h00;
			cmpl_q <= 8'h00;
			pin1_q <= PIN_RST;
			pin2_q <= PIN_RST;
		end else begin
			if (wr_cfg)  cfg_q  <= wd;
			if (wr_sc2)  sc2_q  <= wd & SC2_WMASK;
			if (wr_sc1)  sc1_q  <= {1'b0, wd[6:0]};
			if (wr_cmph) cmph_q <= wd;
			if (wr_cmpl) cmpl_q <= wd;
			if (wr_pin1) pin1_q <= wd;
			if (wr_pin2) pin2_q <= wd;
		end
	end

	// Power mode: leaving deep stop is a write of run after reset
	always_ff @(posedge clk) begin
		if (!resetn)
			pwr_q <= PWR_RUN;
		else if (wr_pwr)
			pwr_q <= wd[1:0];
	end

	// Result and completion flag; stop3 leaves result untouched
	always_ff @(posedge clk) begin
		if (sreset) begin
			res_q     <= 10'h000;
			completion_flag_q    <= 1'b0;
			hi_read_q <= 1'b0;
		end else begin
			if (transfer)
				res_q <= sc2_q[SC2_CFE] ? cmp_diff : conv_res;
			if (transfer)
				completion_flag_q <= 1'b1;
			else if (wr_sc1 || rd_resl)
				completion_flag_q <= 1'b0;
			if (rd_resh)
				hi_read_q <= 1'b1;
			else if (rd_resl)
				hi_read_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk) begin
		if (sreset) begin
			st_q  <= ACC_IDLE;
			cnt_q <= '0;
			bit_q <= 4'd0;
			sar_q <= 10'h000;
			div_q <= 4'd0;
			act_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			// Free toggle gives the half-rate bus tick
			half_q <= !half_q;
			if (src_tick)
				div_q <= conversion_clock ? 4'd0 : 4'(div_q + 4'd1);
			if (start && !(abort && !sw_start)) begin
				st_q  <= ACC_SAMPLE;
				cnt_q <= CNT_W'(cfg_q[CFG_LSMP] ? SMP_LONG : SMP_SHORT);
				act_q <= 1'b1;
			end else if (abort) begin
				st_q  <= ACC_IDLE;
				act_q <= 1'b0;
			end else if (conversion_clock && !stopped_clk) begin
				case (st_q)
				ACC_SAMPLE: begin
					if (cnt_q == CNT_W'(1)) begin
						st_q  <= ACC_CONVERT;
						bit_q <= nbits;
						sar_q <= analog_sample;
					end else begin
						cnt_q <= CNT_W'(cnt_q - CNT_W'(1));
					end
				end
				ACC_CONVERT: begin
					if (compare_step)
						bit_q <= 4'(bit_q - 4'd1);
					if (conv_done) begin
						st_q  <= ACC_IDLE;
						act_q <= 1'b0;
					end
				end
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and bus answer
	wire [7:0] sc1_rd = {completion_flag_q, sc1_q[6:0]};
	wire [7:0] sc2_rd = {act_q, sc2_q[6:4], 4'h0};
	wire [7:0] rdat =
		avs_address == OFF_CFG  ? cfg_q  :
		avs_address == OFF_SC2  ? sc2_rd :
		avs_address == OFF_SC1  ? sc1_rd :
		avs_address == OFF_RESH ? {6'h00, res_q[9:8]} :
		avs_address == OFF_RESL ? res_q[7:0] :
		avs_address == OFF_CMPH ? cmph_q :
		avs_address == OFF_CMPL ? cmpl_q :
		avs_address == OFF_PIN1 ? pin1_q :
		avs_address == OFF_PIN2 ? pin2_q :
		avs_address == OFF_PWR  ? {6'h00, pwr_q} : 8'h00;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ack_q           <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			ack_q           <= (avs_read | avs_write) & !ack_q;
			avs_waitrequest <= !((avs_read | avs_write) & !ack_q);
			if (avs_read & !ack_q)
				avs_readdata <= {24'h000000, rdat};
		end
	end

	always_ff @(posedge clk) begin
		if (sreset) begin
			analog_channel      <= CH_OFF;
			sample_request      <= 1'b0;
			pin_digital_disable <= 16'h0000;
			wake_irq            <= 1'b0;
		end else begin
			analog_channel      <= sc1_q[4:0];
			sample_request      <= st_q == ACC_SAMPLE;
			pin_digital_disable <= {pin2_q, pin1_q};
			wake_irq            <= completion_flag_q & sc1_q[SC1_IEN];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_stop3_abort: assert property (@(posedge clk) disable iff (!resetn)
		stop3_kill |=> st_q == ACC_IDLE && !act_q)
		else $error("stop3 did not abort");
	a_result_hold: assert property (@(posedge clk) disable iff (sreset)
		!$past(transfer) |-> $stable(res_q))
		else $error("result changed without transfer");
	a_idle_stays: assert property (@(posedge clk) disable iff (!resetn)
		st_q == ACC_IDLE && !start |=> st_q == ACC_IDLE)
		else $error("left idle without trigger");
	a_flag_sets: assert property (@(posedge clk) disable iff (sreset)
		transfer |=> completion_flag_q ##1
		wake_irq == $past(completion_flag_q && sc1_q[SC1_IEN]))
		else $error("flag or wake missing");
	a_sc2_zero: assert property (@(posedge clk) disable iff (!resetn)
		sc2_q[3:0] == 4'h0)
		else $error("control two low bits nonzero");
	a_block_xfer: assert property (@(posedge clk) disable iff (sreset)
		conv_done && blocked |=> !$changed(res_q))
		else $error("blocked result transferred");
	a_write_abort: assert property (@(posedge clk) disable iff (sreset)
		wr_sc1 && wd[4:0] == CH_OFF |=> st_q == ACC_IDLE)
		else $error("all-ones channel started");
	a_active_flag: assert property (@(posedge clk) disable iff (sreset)
		act_q == (st_q != ACC_IDLE))
		else $error("active flag mismatch");
endmodule

// file: test/tb_top.sv
// Testbench: registers, conversions, compare and low-power behaviour
`timescale 1ns/1ns
module tb_top;
	import acc_pkg::*;
	localparam logic [7:0] P_RUN  = {6'h00, PWR_RUN};
	localparam logic [7:0] P_STP3 = {6'h00, PWR_STOP3};
	localparam logic [7:0] P_DEEP = {6'h00, PWR_DEEP};
	logic        clk;
	logic        resetn;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        async_clk_tick;
	logic        hw_trigger;
	logic [4:0]  analog_channel;
	logic        sample_request;
	logic [9:0]  analog_sample;
	logic [15:0] pin_digital_disable;
	logic        wake_irq;
	logic        tick_en;
	logic [7:0]  d;
	int          miscompares;
	int          n_tests;
	int          smp;
	int          cmp;

	acc_core dut_u (
		.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.async_clk_tick(async_clk_tick), .hw_trigger(hw_trigger),
		.analog_channel(analog_channel), .sample_request(sample_request),
		.compare_step(1'h1), .analog_sample(analog_sample),
		.pin_digital_disable(pin_digital_disable), .wake_irq(wake_irq)
	);

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// Random asynchronous clock ticks
	always @(posedge clk) begin
		async_clk_tick <= tick_en & 1'($urandom);
	end

	////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, v};
		avs_write     <= 1'h1;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		avs_write <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_read    <= 1'h1;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		v = avs_readdata[7:0];
		avs_read <= 1'h0;
	endtask

	// Poll completion flag a bounded number of times
	task automatic wait_cc(input int lim, output logic [7:0] v);
		repeat (lim) begin
			rd(OFF_SC1, v);
			if (v[SC1_COMPLETION_FLAG] === 1'h1)
				break;
		end
	endtask

	// High byte first, then low byte
	task automatic chk_res(input int e);
		logic [7:0] hi;
		logic [7:0] lo;
		rd(OFF_RESH, hi);
		rd(OFF_RESL, lo);
		chk({22'h000000, hi[1:0], lo}, e & 32'h000003FF);
	endtask

	task automatic new_sample(input int lo_lim);
		smp = $urandom_range(lo_lim, 1023);
		analog_sample <= smp[9:0];
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		complete_run;
	end

	initial begin
		resetn = 1'h0; avs_address = 4'h0; avs_read = 1'h0;
		avs_write = 1'h0; avs_writedata = 32'h00000000;
		async_clk_tick = 1'h0; hw_trigger = 1'h0;
		analog_sample = 10'h000; tick_en = 1'h0;
		miscompares = 0; n_tests = 0;
		void'($urandom(67));
		repeat (16) @(posedge clk);
		resetn <= 1'h1;
		rd(OFF_SC1, d); chk(d, SC1_RST);
		rd(4'hA, d); chk(d, 8'h00);
		wr(OFF_CFG, 8'h98); rd(OFF_CFG, d); chk(d, 8'h98);
		smp = $urandom & 32'h0000007C;
		wr(OFF_SC2, smp[7:0]); rd(OFF_SC2, d); chk(d, smp & 32'h70);
		wr(OFF_SC2, 8'h00);
		wr(OFF_PIN1, 8'h02); wr(OFF_PIN2, 8'h00); rd(OFF_PIN1, d);
		chk(pin_digital_disable, 16'h0002);
		// Single software conversion on channel 1
		new_sample(1);
		wr(OFF_SC1, 8'h41); rd(OFF_SC2, d); chk(d[SC2_ACT], 1'h1);
		chk(analog_channel, 5'h01);
		chk(sample_request, 1'h1);
		wait_cc(100, d); chk(d, 8'hC1);
		chk(wake_irq, 1'h1);
		chk_res(smp);
		repeat (200) @(posedge clk);
		rd(OFF_SC1, d); chk(d, 8'h41);
		rd(OFF_SC2, d); chk(d[SC2_ACT], 1'h0);
		// Stop3 on bus clock aborts, results kept
		analog_sample <= ~smp[9:0];
		wr(OFF_SC1, 8'h41); wr(OFF_PWR, P_STP3);
		rd(OFF_SC2, d); chk(d[SC2_ACT], 1'h0);
		wr(OFF_PWR, P_RUN); repeat (200) @(posedge clk);
		rd(OFF_SC1, d); chk(d[SC1_COMPLETION_FLAG], 1'h0);
		chk_res(smp);
		// High byte read blocks transfers
		wr(OFF_SC1, 8'h41); rd(OFF_RESH, d); repeat (200) @(posedge clk);
		rd(OFF_SC1, d); chk(d[SC1_COMPLETION_FLAG], 1'h0);
		rd(OFF_RESL, d); wr(OFF_SC1, 8'h1F);
		rd(OFF_SC2, d); chk(d[SC2_ACT], 1'h0);
		chk(analog_channel, 5'h1F);
		// Compare: upper limit met, lower limit not met
		wr(OFF_CFG, 8'h08); new_sample(1); cmp = $urandom_range(0, smp);
		wr(OFF_CMPH, cmp[15:8]); wr(OFF_CMPL, cmp[7:0]);
		wr(OFF_SC2, 8'h30); wr(OFF_SC1, 8'h01);
		wait_cc(100, d); chk(d[SC1_COMPLETION_FLAG], 1'h1);
		chk_res(smp - cmp);
		wr(OFF_SC2, 8'h20); wr(OFF_SC1, 8'h01);
		wait_cc(60, d); chk(d[SC1_COMPLETION_FLAG], 1'h0);
		wr(OFF_SC1, 8'h1F); wr(OFF_SC2, 8'h00);
		// Async clock keeps converting through stop3
		tick_en <= 1'h1; wr(OFF_CFG, 8'h0B); new_sample(0);
		rd(OFF_RESL, d);
		wr(OFF_SC1, 8'h41); wr(OFF_PWR, P_STP3);
		wait_cc(300, d); chk(d[SC1_COMPLETION_FLAG], 1'h1);
		chk(wake_irq, 1'h1);
		chk_res(smp);
		// Hardware trigger while in stop3
		wr(OFF_PWR, P_RUN); wr(OFF_SC2, 8'h40); wr(OFF_SC1, 8'h41);
		// Let the write-started conversion finish and clear the flag
		wait_cc(300, d); rd(OFF_RESH, d); rd(OFF_RESL, d);
		wr(OFF_PWR, P_STP3); new_sample(0);
		@(posedge clk);
		hw_trigger <= 1'h1;
		repeat (4) @(posedge clk);
		hw_trigger <= 1'h0;
		wait_cc(300, d); chk(d[SC1_COMPLETION_FLAG], 1'h1);
		chk_res(smp);
		// Deep stop returns every register except the power mode to reset
		wr(OFF_PWR, P_RUN); wr(OFF_PWR, P_DEEP); wr(OFF_PWR, P_RUN);
		rd(OFF_CFG, d); chk(d, CFG_RST);
		rd(OFF_SC2, d); chk(d, SC2_RST);
		rd(OFF_SC1, d); chk(d, SC1_RST);
		chk(pin_digital_disable, 16'h0000);
		wr(OFF_CFG, 8'h08); new_sample(0); wr(OFF_SC1, 8'h01);
		wait_cc(100, d); chk(d[SC1_COMPLETION_FLAG], 1'h1);
		chk_res(smp);
		complete_run;
	end
endmodule
